// ### core/pmc_pkg.sv
// Package: register map, field positions and modes of the power control block
package pmc_pkg;
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CLK = 8'h1c;
	localparam logic [7:0] IDX_EN1 = 8'h1d;
	localparam logic [7:0] IDX_HID = 8'h66;
	localparam logic [7:0] IDX_STAT = 8'h40;
	localparam logic [7:0] IDX_MASK = 8'h41;
	localparam logic [7:0] IDX_AUTO = 8'h42;
	// Keypad clock gate fields
	localparam int CLK_KPAD_BIT = 7;
	// Block enable one fields
	localparam int EN_PWR_BIT = 7;
	localparam int EN_SLEEP_BIT = 6;
	localparam int EN_RSV_BIT = 5;
	localparam int EN_MICB_BIT = 4;
	localparam int EN_KS_BIT = 2;
	// Automatic configuration field, low bits of its register
	localparam int AUTO_W = 2;
	localparam logic [1:0] AUTO_RUN_A = 2'h1;
	localparam logic [1:0] AUTO_RUN_B = 2'h2;
	// Event bits shared by status and mask
	localparam int EV_INS = 0;
	localparam int EV_REM = 1;
	localparam int EV_BTN = 2;
	localparam int EV_N = 3;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_AUTO = 2'h0;
	// Power modes
	typedef enum logic [1:0] {PMC_SHUTDOWN, PMC_SLEEP, PMC_NORMAL} pmc_mode_e;
endpackage

// ### core/pmc_mode.sv
// Power mode state machine with detection start pulse
`timescale 1ns/100ps
module pmc_mode
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic power_on_i,
	input wire logic sleep_i,
	output pmc_pkg::pmc_mode_e mode_o,
	output logic start_o
);
	import pmc_pkg::*;

	pmc_mode_e mode_ff; // Current mode
	pmc_mode_e nxt_mode; // Next mode
	logic start_ff; // One cycle on leaving shutdown
	logic nxt_start;

	// Mode selection; sleep counts only while powered
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_start = 1'b0;
		unique case (mode_ff)
			PMC_SHUTDOWN:
			begin
				// Sleep ignored while powered off
				if (power_on_i)
				begin
					nxt_mode = sleep_i ? PMC_SLEEP : PMC_NORMAL;
					nxt_start = 1'b1;
				end
			end
			PMC_SLEEP:
			begin
				if (!power_on_i)
					nxt_mode = PMC_SHUTDOWN;
				else if (!sleep_i)
					nxt_mode = PMC_NORMAL;
			end
			PMC_NORMAL:
			begin
				if (!power_on_i)
					nxt_mode = PMC_SHUTDOWN;
				else if (sleep_i)
					nxt_mode = PMC_SLEEP;
			end
			// Illegal code falls back to the safest state
			default: nxt_mode = PMC_SHUTDOWN;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			mode_ff <= PMC_SHUTDOWN;
			start_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			start_ff <= nxt_start;
		end
	end

	assign mode_o = mode_ff;
	assign start_o = start_ff;

	// Start pulse exactly one cycle after power bit rises
	start_pulse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(mode_ff == PMC_SHUTDOWN && power_on_i) |=> start_ff ##1 !start_ff)
		else $error("detect start not a single pulse");
endmodule // pmc_mode

// ### core/pmc_irq.sv
// Sticky event status with mask and one level interrupt
`timescale 1ns/100ps
module pmc_irq
#(
	parameter int N = 3
)
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [N-1:0] event_i,
	input wire logic [N-1:0] clear_i,
	input wire logic [N-1:0] mask_i,
	output logic [N-1:0] status_o,
	output logic irq_o
);
	logic [N-1:0] status_ff; // Sticky flags
	logic irq_ff; // Registered interrupt level
	logic [N-1:0] nxt_status;

	localparam int EV_BIT = N - 1; // Top flag, watched by the set-wins check

	// Elaboration check: the flag word must fit one register byte
	if (N < 1 || N > 8)
	begin : g_bad_n
		$error("pmc_irq: N must be 1 to 8");
	end

	// Per bit: a set in the clear cycle wins, so no event is lost
	for (genvar g = 0; g < N; g++)
	begin : g_bit
		assign nxt_status[g] = event_i[g] | (status_ff[g] & ~clear_i[g]);
	end

	// Flags and interrupt level
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			status_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			status_ff <= nxt_status;
			irq_ff <= |(nxt_status & mask_i);
		end
	end

	assign status_o = status_ff;
	assign irq_o = irq_ff;

	// Set beats clear in the same cycle
	set_wins_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(event_i[EV_BIT] && clear_i[EV_BIT]) |=> status_ff[EV_BIT])
		else $error("event lost against clear");
endmodule // pmc_irq

// ### core/pmc_top.sv
// Power mode and keypad clock control register bank behind APB
`timescale 1ns/100ps
module pmc_top
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
	input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
	output logic [pmc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic jack_sense_i,
	input wire logic jack_switch_broken_i,
	input wire logic button_press_i,
	input wire logic auto_mic_bias_i,
	input wire logic keyscan_active_i,
	output logic mic_bias_en_o,
	output logic keypad_clk_en_o,
	output logic jack_inserted_o,
	output logic removal_arm_o,
	output logic button_watch_o,
	output logic detect_start_o,
	output logic active_o,
	output logic irq_o
);
	import pmc_pkg::*;

	// Byte addresses built from the indices
	localparam logic [ADDR_W-1:0] A_CLK = {2'h0, IDX_CLK, 2'h0};
	localparam logic [ADDR_W-1:0] A_EN1 = {2'h0, IDX_EN1, 2'h0};
	localparam logic [ADDR_W-1:0] A_HID = {2'h0, IDX_HID, 2'h0};
	localparam logic [ADDR_W-1:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
	localparam logic [ADDR_W-1:0] A_MASK = {2'h0, IDX_MASK, 2'h0};
	localparam logic [ADDR_W-1:0] A_AUTO = {2'h0, IDX_AUTO, 2'h0};

	// Software state
	logic kpad_clk_ff; // Keypad clock request
	logic power_on_ff; // Power bit
	logic sleep_ff; // Sleep enable
	logic mic_bias_ff; // Manual mic bias enable
	logic [REG_W-1:0] hid_ff; // Last hidden register value
	logic [EV_N-1:0] mask_ff; // Interrupt mask
	logic [AUTO_W-1:0] auto_ff; // Automatic configuration field
	// Bus answer
	logic pready_ff;
	logic pslverr_ff;
	logic [DATA_W-1:0] prdata_ff;
	// Block outputs held in flops
	logic mic_bias_en_ff;
	logic kpad_en_ff;
	logic ins_ff; // Reported insertion
	logic watch_ff;
	logic active_ff;

	// Wires between parts
	pmc_mode_e mode;
	logic start;
	logic [EV_N-1:0] status;
	logic irq;

	// Bus decode
	wire setup = psel & ~penable & ~pready_ff;
	wire wr_fire = psel & penable & pready_ff & pwrite;
	wire hit_clk = paddr == A_CLK;
	wire hit_en1 = paddr == A_EN1;
	wire hit_hid = paddr == A_HID;
	wire hit_stat = paddr == A_STAT;
	wire hit_mask = paddr == A_MASK;
	wire hit_auto = paddr == A_AUTO;
	wire mapped = hit_clk | hit_en1 | hit_hid | hit_stat | hit_mask
		| hit_auto;
	wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];

	// Mode and derived levels
	wire in_normal = mode == PMC_NORMAL;
	wire in_sleep = mode == PMC_SLEEP;
	wire in_power_on_bit = mode == PMC_SHUTDOWN;
	// Mic bias enable turns into status while auto runs
	wire auto_ro = (auto_ff == AUTO_RUN_A) | (auto_ff == AUTO_RUN_B);
	// Broken switch fakes insertion only when shut down
	// Sleep and normal trust the sense input
	wire ins_now = (in_power_on_bit & jack_switch_broken_i) | jack_sense_i;
	// Buttons watched in sleep and normal, not in shutdown
	wire watch_now = in_sleep | in_normal;
	wire mic_bias_now = auto_ro ? auto_mic_bias_i : mic_bias_ff;
	// Keypad clock only in normal mode with a jack present
	wire kpad_now = kpad_clk_ff & in_normal & ins_ff;

	// Events into the sticky status
	wire [EV_N-1:0] events;
	assign events[EV_INS] = ins_now & ~ins_ff;
	assign events[EV_REM] = ~ins_now & ins_ff;
	assign events[EV_BTN] = button_press_i & watch_ff;
	wire [EV_N-1:0] w1c = (wr_fire & hit_stat) ? wbyte[EV_N-1:0]
		: {EV_N{1'b0}};

	// Read view of the enable register
	wire [REG_W-1:0] en1_view;
	// Unlisted bits, the reserved one among them, read zero
	assign en1_view = (REG_W'(power_on_ff) << EN_PWR_BIT)
		| (REG_W'(sleep_ff) << EN_SLEEP_BIT)
		| (REG_W'(mic_bias_now) << EN_MICB_BIT)
		| (REG_W'(keyscan_active_i) << EN_KS_BIT);

	// Reserved clock gate bits read back as zero
	wire [REG_W-1:0] clk_view = {kpad_clk_ff, 7'h00};

	// Read data selection
	wire [REG_W-1:0] rbyte =
		hit_clk ? clk_view :
		hit_en1 ? en1_view :
		hit_hid ? hid_ff :
		hit_stat ? {{(REG_W-EV_N){1'b0}}, status} :
		hit_mask ? {{(REG_W-EV_N){1'b0}}, mask_ff} :
		hit_auto ? {{(REG_W-AUTO_W){1'b0}}, auto_ff} : RST_BYTE;

	// Mode machine
	pmc_mode u_mode
	(
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.power_on_i(power_on_ff),
		.sleep_i(sleep_ff),
		.mode_o(mode),
		.start_o(start)
	);

	// Event flags and interrupt
	pmc_irq #(.N(EV_N)) u_irq
	(
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.event_i(events),
		.clear_i(w1c),
		.mask_i(mask_ff),
		.status_o(status),
		.irq_o(irq)
	);

	// Bus answer: ready in the first access cycle, no waits
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff <= setup ? {{(DATA_W-REG_W){1'b0}}, rbyte} : '0;
		end
	end

	// Clock gate register; hardware drops it outside normal mode
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			kpad_clk_ff <= RST_BYTE[CLK_KPAD_BIT];
		else if (!in_normal)
			kpad_clk_ff <= 1'b0;
		else if (wr_fire && hit_clk)
			kpad_clk_ff <= wbyte[CLK_KPAD_BIT];
	end

	// Power and sleep bits stay writable in every mode
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			power_on_ff <= RST_BYTE[EN_PWR_BIT];
			sleep_ff <= RST_BYTE[EN_SLEEP_BIT];
		end
		else if (wr_fire && hit_en1)
		begin
			power_on_ff <= wbyte[EN_PWR_BIT];
			sleep_ff <= wbyte[EN_SLEEP_BIT];
		end
	end

	// Manual mic bias; a write under auto is dropped
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			mic_bias_ff <= RST_BYTE[EN_MICB_BIT];
		else if (wr_fire && hit_en1 && !auto_ro)
			mic_bias_ff <= wbyte[EN_MICB_BIT];
	end

	// Hidden, mask and auto registers
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			hid_ff <= RST_BYTE;
			mask_ff <= '0;
			auto_ff <= RST_AUTO;
		end
		else
		begin
			if (wr_fire && hit_hid)
				hid_ff <= wbyte;
			if (wr_fire && hit_mask)
				mask_ff <= wbyte[EV_N-1:0];
			if (wr_fire && hit_auto)
				auto_ff <= wbyte[AUTO_W-1:0];
		end
	end

	// Output flops
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			mic_bias_en_ff <= 1'b0;
			kpad_en_ff <= 1'b0;
			ins_ff <= 1'b0;
			watch_ff <= 1'b0;
			active_ff <= 1'b0;
		end
		else
		begin
			mic_bias_en_ff <= mic_bias_now;
			kpad_en_ff <= kpad_now;
			ins_ff <= ins_now;
			watch_ff <= watch_now;
			active_ff <= ~in_power_on_bit;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign mic_bias_en_o = mic_bias_en_ff;
	assign keypad_clk_en_o = kpad_en_ff;
	assign jack_inserted_o = ins_ff;
	// Removal watch armed whenever a jack is seen
	assign removal_arm_o = ins_ff;
	assign button_watch_o = watch_ff;
	assign detect_start_o = start;
	assign active_o = active_ff;
	assign irq_o = irq;

	// Keypad bit sits at bit 7, nothing else reads back
	clk_view_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(pready_ff && hit_clk && psel) |-> prdata_ff[6:0] == 7'h00)
		else $error("clock gate reserved bits not zero");

	// Write under auto leaves manual bias untouched
	sequence auto_write_s;
		wr_fire && hit_en1 && auto_ro;
	endsequence
	ro_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		auto_write_s |=> $stable(mic_bias_ff))
		else $error("read-only enable bit changed");

	// Under auto the bias output follows the algorithm
	auto_bias_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		auto_ro |=> mic_bias_en_o == $past(auto_mic_bias_i))
		else $error("bias not from algorithm under auto");

	// Removal armed the cycle after insertion is seen
	arm_track_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		ins_now |=> removal_arm_o)
		else $error("removal detect not armed");

	// Power bit low keeps the block shut down whatever sleep says
	low_power_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!power_on_ff && in_power_on_bit) |=> !active_o && !button_watch_o)
		else $error("active while powered off");

	// Broken switch while shut down reports inserted
	fake_ins_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(in_power_on_bit && jack_switch_broken_i) |=> jack_inserted_o)
		else $error("broken switch not reported inserted");

	// Power bit rise leads to a start pulse two cycles later
	sequence power_rise_s;
		wr_fire && hit_en1 && wbyte[EN_PWR_BIT] && !power_on_ff;
	endsequence
	start_algo_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		power_rise_s |=> ##1 detect_start_o)
		else $error("detection not started");

	// Sleep button press raises its flag next cycle
	btn_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(in_sleep && watch_ff && button_press_i) |=> status[EV_BTN])
		else $error("button press flag missed");

	// Sleep mode ignores the broken switch
	sleep_sense_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		in_sleep |=> jack_inserted_o == $past(jack_sense_i))
		else $error("sleep insertion not from sense");

	// Powered with sleep low ends in normal mode
	normal_mode_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(power_on_ff && !sleep_ff) |=> in_normal)
		else $error("not normal with sleep clear");

	// Reserved enable bit and status bit on reads
	en1_view_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(setup && hit_en1) |=> !prdata[EN_RSV_BIT]
			&& prdata[EN_KS_BIT] == $past(keyscan_active_i))
		else $error("enable readback wrong");
endmodule // pmc_top

// ### tb/pmc_env.sv
// Accessory model on the jack side of the power control block
`timescale 1ns/100ps
module pmc_env
(
	input wire logic sys_clk_i,
	input wire logic plug_i,
	input wire logic broken_i,
	input wire logic press_i,
	input wire logic bias_i,
	input wire logic kclk_i,
	output logic jack_sense_o,
	output logic broken_o,
	output logic button_o,
	output logic bias_o,
	output logic keyscan_o
);
	// Levels move one edge after the bench asks, like real contacts
	always @(posedge sys_clk_i)
	begin
		jack_sense_o <= plug_i;
		broken_o <= broken_i;
		// A button exists only on a plugged headset
		button_o <= press_i & plug_i;
		bias_o <= bias_i;
		// Scan converter runs only while its clock is on
		keyscan_o <= kclk_i;
	end
endmodule // pmc_env

// ### tb/tb_top.sv
// Self-checking bench of the power control register bank
`timescale 1ns/100ps
module tb_top;
	import pmc_pkg::*;
	logic sys_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic plug, broken, press, bias, jsense, jbroken, btn, abias, kscan;
	logic mic, kclk, ins, rem, watch, dstart, act, irq;
	int n_errors, checks_done;
	logic [32:0] expq[$]; // Notes of expected {pslverr, prdata}
	logic [31:0] seed;
	// Free-running bus clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	pmc_top i_pmc_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .jack_sense_i(jsense),
		.jack_switch_broken_i(jbroken), .button_press_i(btn),
		.auto_mic_bias_i(abias), .keyscan_active_i(kscan),
		.mic_bias_en_o(mic), .keypad_clk_en_o(kclk),
		.jack_inserted_o(ins), .removal_arm_o(rem),
		.button_watch_o(watch), .detect_start_o(dstart),
		.active_o(act), .irq_o(irq));
	pmc_env i_pmc_env (.sys_clk_i(sys_clk_i), .plug_i(plug),
		.broken_i(broken), .press_i(press), .bias_i(bias), .kclk_i(kclk),
		.jack_sense_o(jsense), .broken_o(jbroken), .button_o(btn),
		.bias_o(abias), .keyscan_o(kscan));
	// Xorshift source for filler and hidden register data
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [6:0] outs();
		return {mic, kclk, ins, rem, watch, act, irq};
	endfunction
	task automatic chk(input string nm, input logic [32:0] e,
		input logic [32:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; upper data bits are random and must be ignored
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic [32:0] e);
		logic [31:0] r;
		r = xs();
		expq.push_back(e);
		@(posedge sys_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ADDR_W'({idx, 2'h0});
		pwdata <= {r[31:8], d};
		@(posedge sys_clk_i);
		penable <= 1'b1;
		@(posedge sys_clk_i);
		while (pready !== 1'b1)
			@(posedge sys_clk_i);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 33'h0_0000_0000);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00, {25'h000_0000, e});
	endtask
	// Hidden register write sequence, oldest byte highest
	task automatic hseq(input logic [39:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			wr(IDX_HID, v[8*i+:8]);
	endtask
	// Level outputs settle within a few edges; looked at mid-cycle
	task automatic wait_outs(input logic [6:0] m, input logic [6:0] e);
		int k;
		k = 0;
		@(negedge sys_clk_i);
		while (((outs() & m) !== e) && k < 10)
		begin
			@(negedge sys_clk_i);
			k++;
		end
		chk("ports", {26'h0, e}, {26'h0, outs() & m});
		// Hand back on a rising edge, where the bench drives
		@(posedge sys_clk_i);
	endtask
	task automatic pulse();
		@(posedge sys_clk_i);
		press <= 1'b1;
		@(posedge sys_clk_i);
		press <= 1'b0;
	endtask
	// Takes the oldest note whenever a transfer completes
	always @(posedge sys_clk_i)
	begin
		if (psel && penable && pready === 1'b1 && expq.size() > 0)
		begin
			chk("apb", expq[0], {pslverr, pwrite ? expq[0][31:0] : prdata});
			void'(expq.pop_front());
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Cuts a hang short; the tests need a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		$display("watchdog expired");
		test_done();
	end
	// Main sequence
	initial
	begin
		seed = 32'h0000_0060;
		n_errors = 0;
		checks_done = 0;
		sys_rst_i = 1'b1;
		{psel, penable, pwrite, plug, broken, press, bias} = 7'h00;
		paddr = '0;
		pwdata = '0;
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		wait_outs(7'h7f, 7'h00);
		rd(IDX_CLK, 8'h00);
		rd(IDX_EN1, 8'h00);
		rd(IDX_STAT, 8'h00);
		rd(IDX_MASK, 8'h00);
		rd(IDX_AUTO, 8'h00);
		xfer(1'b0, 8'hff, 8'h00, 33'h1_0000_0000); // Unmapped read
		xfer(1'b1, 8'hff, 8'h5a, 33'h1_0000_0000); // Unmapped write
		$display("test reset done");
		wr(IDX_CLK, 8'h00);
		wr(IDX_CLK, 8'h80); // Refused outside normal mode
		rd(IDX_CLK, 8'h00);
		broken <= 1'b1;
		wait_outs(7'h18, 7'h18);
		broken <= 1'b0;
		wait_outs(7'h18, 7'h00);
		wr(IDX_MASK, 8'h01);
		wr(IDX_STAT, 8'h07);
		plug <= 1'b1;
		wait_outs(7'h19, 7'h19);
		rd(IDX_STAT, 8'h01);
		wr(IDX_STAT, 8'h01);
		wait_outs(7'h01, 7'h00);
		pulse();
		repeat (3) @(posedge sys_clk_i);
		rd(IDX_STAT, 8'h00);
		$display("test shutdown done");
		wr(IDX_EN1, 8'h80);
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk("start", 33'h1, {32'h0, dstart});
		@(negedge sys_clk_i);
		chk("start", 33'h0, {32'h0, dstart});
		wait_outs(7'h06, 7'h06);
		wr(IDX_CLK, 8'h80);
		hseq(40'h00_00f1_0100, 3);
		wait_outs(7'h20, 7'h20);
		rd(IDX_CLK, 8'h80);
		rd(IDX_EN1, 8'h84);
		wr(IDX_EN1, 8'hb4);
		rd(IDX_EN1, 8'h94);
		wait_outs(7'h40, 7'h40);
		for (int i = 0; i < 4; i++)
		begin
			logic [7:0] v;
			v = 8'(xs());
			wr(IDX_HID, v);
			rd(IDX_HID, v);
		end
		$display("test normal done");
		for (int m = 1; m < 3; m++)
		begin
			bias <= 1'b0;
			wr(IDX_AUTO, 8'(m));
			wait_outs(7'h40, 7'h00);
			wr(IDX_EN1, 8'h80);
			rd(IDX_EN1, 8'h84);
			bias <= 1'b1;
			wait_outs(7'h40, 7'h40);
			rd(IDX_EN1, 8'h94);
		end
		wr(IDX_AUTO, 8'h03);
		rd(IDX_EN1, 8'h94);
		wr(IDX_EN1, 8'h80);
		rd(IDX_EN1, 8'h84);
		wait_outs(7'h40, 7'h00);
		wr(IDX_AUTO, 8'h00);
		$display("test auto done");
		wr(IDX_EN1, 8'hc0);
		wait_outs(7'h26, 7'h06);
		rd(IDX_CLK, 8'h00);
		hseq(40'hf1_f1f1_0000, 5);
		wr(IDX_MASK, 8'h04);
		pulse();
		wait_outs(7'h01, 7'h01);
		rd(IDX_STAT, 8'h04);
		wr(IDX_STAT, 8'h04);
		wait_outs(7'h01, 7'h00);
		broken <= 1'b1;
		plug <= 1'b0;
		wait_outs(7'h18, 7'h00);
		plug <= 1'b1;
		broken <= 1'b0;
		wr(IDX_EN1, 8'h40);
		wait_outs(7'h06, 7'h00);
		$display("test sleep done");
		test_done();
	end
endmodule // tb_top
